/* core/fbsd_slave.sv */
// slave end: parameter decode, configuration check, data and diagnostics
// assumes the master sends one request at a time and waits for the answer
`timescale 1ns/1ps
`include "fbsd_defs.svh"
module fbsd_slave #(
  parameter int IO_BYTES = `FBSD_IO_BYTES,
  parameter int TICKS_PER_MS = `FBSD_TICKS_PER_MS
) (
  input wire logic clock,
  input wire logic arst_n,
  fbsd_link_if.slave link,
  input wire logic [10:0] bus_fault_evt,
  input wire logic [8*IO_BYTES-1:0] inputs_img,
  output logic [8*IO_BYTES-1:0] outputs_img_ff,
  output logic outputs_upd_ff,
  output logic [3:0] frame_format_ff,
  output logic [15:0] poll_interval_ff,
  output logic poll_query_ff,
  output logic prm_ok_ff,
  output logic cfg_ok_ff
);
  // ==========================================================
  // request capture
  logic [7:0] idx_ff;
  fbsd_pkg::fbsd_req_type kind_ff;
  logic [7:0] fmt_byte_ff;
  logic [7:0] cyc_hi_ff;
  logic [7:0] cyc_lo_ff;
  logic cfg_bad_ff;
  logic [8*IO_BYTES-1:0] out_sh_ff;
  logic end_evt;
  logic [7:0] pos;
  logic [7:0] up_pos;
  assign end_evt = link.req_valid && link.req_last;
  assign pos = link.req_start ? 8'h00 : idx_ff;
  assign up_pos = pos - 8'(`FBSD_PRM_STD_LEN + `FBSD_PRM_IGNORED);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idx_ff <= 8'h00;
      kind_ff <= fbsd_pkg::FBSD_REQ_NONE;
    end else if (link.req_start) begin
      idx_ff <= link.req_valid ? 8'h01 : 8'h00;
      kind_ff <= link.req_kind;
    end else if (link.req_valid && idx_ff != 8'hff) begin
      idx_ff <= idx_ff + 8'h01;
    end
  end

  fbsd_pkg::fbsd_req_type cur_kind;
  assign cur_kind = link.req_start ? link.req_kind : kind_ff;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fmt_byte_ff <= 8'h00;
      cyc_hi_ff <= 8'h00;
      cyc_lo_ff <= 8'h00;
    end else if (link.req_valid && cur_kind == fbsd_pkg::FBSD_REQ_PRM) begin
      if (pos >= 8'(`FBSD_PRM_STD_LEN + `FBSD_PRM_IGNORED)) begin
        if (up_pos == 8'(`FBSD_UP_FMT_IDX)) fmt_byte_ff <= link.req_byte;
        if (up_pos == 8'(`FBSD_UP_CYC_HI_IDX)) cyc_hi_ff <= link.req_byte;
        if (up_pos == 8'(`FBSD_UP_CYC_LO_IDX)) cyc_lo_ff <= link.req_byte;
      end
    end
  end

  // configuration identifier check, one slot, standard module only
  logic [7:0] cfg_exp;
  always_comb begin
    case (pos)
      8'h00: cfg_exp = `FBSD_CFG_B0;
      8'h01: cfg_exp = `FBSD_CFG_B1;
      8'h02: cfg_exp = `FBSD_CFG_B2;
      8'h03: cfg_exp = `FBSD_CFG_B3;
      default: cfg_exp = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_bad_ff <= 1'b0;
    end else if (link.req_valid && cur_kind == fbsd_pkg::FBSD_REQ_CFG) begin
      cfg_bad_ff <= (link.req_start ? 1'b0 : cfg_bad_ff)
        || pos >= 8'(`FBSD_CFG_LEN) || link.req_byte != cfg_exp;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_sh_ff <= '0;
    end else if (link.req_valid && cur_kind == fbsd_pkg::FBSD_REQ_DATA) begin
      out_sh_ff <= {link.req_byte, out_sh_ff[8*IO_BYTES-1:8]};
    end
  end

  // ==========================================================
  // settings commit and state
  logic [15:0] new_cyc;
  logic [3:0] new_fmt;
  logic prm_good;
  logic prm_len_ok;
  logic cfg_len_ok;
  logic data_len_ok;
  assign new_cyc = {cyc_hi_ff, cyc_lo_ff};
  assign new_fmt = fmt_byte_ff[3:0];
  assign prm_len_ok = pos >= 8'(`FBSD_PRM_STD_LEN - 1) && pos <= 8'(`FBSD_PRM_MAX_LEN - 1);
  assign cfg_len_ok = pos == 8'(`FBSD_CFG_LEN - 1);
  assign data_len_ok = pos == 8'(IO_BYTES - 1);
  // a short frame without user bytes keeps the previous settings
  assign prm_good = new_cyc >= `FBSD_CYC_MIN && new_cyc <= `FBSD_CYC_MAX
    && new_fmt <= `FBSD_FMT_SPEC_BCAST && fmt_byte_ff[7:4] == 4'h0;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      frame_format_ff <= `FBSD_FMT_RESET;
      poll_interval_ff <= `FBSD_CYC_RESET;
      prm_ok_ff <= 1'b0;
      cfg_ok_ff <= 1'b0;
    end else if (end_evt && cur_kind == fbsd_pkg::FBSD_REQ_PRM) begin
      if (prm_len_ok && (prm_good || pos < 8'(`FBSD_PRM_STD_LEN + `FBSD_PRM_IGNORED + 4))) begin
        if (pos >= 8'(`FBSD_PRM_STD_LEN + `FBSD_PRM_IGNORED + 4)) begin
          frame_format_ff <= new_fmt;
          poll_interval_ff <= new_cyc;
        end
        prm_ok_ff <= 1'b1;
        cfg_ok_ff <= 1'b0;
      end
    end else if (end_evt && cur_kind == fbsd_pkg::FBSD_REQ_CFG) begin
      cfg_ok_ff <= prm_ok_ff && cfg_len_ok && !(cfg_bad_ff || link.req_byte != cfg_exp);
    end
  end

  // ==========================================================
  // sticky internal bus faults and diagnostic flag
  logic [10:0] fault_ff;
  logic diag_pend_ff;
  logic diag_done;
  logic [3:0] dg_idx_ff;
  logic ans_busy_ff;
  logic ans_diag_ff;
  assign diag_done = ans_busy_ff && ans_diag_ff && dg_idx_ff == 4'(`FBSD_DIAG_LEN - 1);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fault_ff <= 11'h000;
    end else begin
      fault_ff <= (diag_done ? fault_ff & ~snap_ff : fault_ff) | bus_fault_evt;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      diag_pend_ff <= 1'b0;
    end else begin
      diag_pend_ff <= (diag_pend_ff && !(diag_done && (fault_ff & ~snap_ff) == 11'h000))
        || (|bus_fault_evt);
    end
  end

  // ==========================================================
  // answer sender
  fbsd_pkg::fbsd_ans_type ans_kind_ff;
  logic [8*IO_BYTES-1:0] in_sh_ff;
  logic [7:0] ans_cnt_ff;
  logic [10:0] snap_ff;
  logic ans_start_ff;
  logic ans_valid_ff;
  logic ans_last_ff;
  logic [7:0] ans_byte_ff;
  logic [7:0] dg_byte;
  always_comb begin
    case (dg_idx_ff)
      4'h0: dg_byte = {6'h00, fault_ff == 11'h000 ? 1'b0 : 1'b1, 1'b0};
      4'h6: dg_byte = `FBSD_DIAG_HDR;
      4'h7: dg_byte = snap_ff[7:0];
      4'h8: dg_byte = {5'h00, snap_ff[10:8]};
      default: dg_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ans_busy_ff <= 1'b0;
      ans_diag_ff <= 1'b0;
      ans_kind_ff <= fbsd_pkg::FBSD_ANS_ACK;
      ans_cnt_ff <= 8'h00;
      dg_idx_ff <= 4'h0;
      in_sh_ff <= '0;
      snap_ff <= 11'h000;
      ans_start_ff <= 1'b0;
      ans_valid_ff <= 1'b0;
      ans_last_ff <= 1'b0;
      ans_byte_ff <= 8'h00;
      outputs_img_ff <= '0;
      outputs_upd_ff <= 1'b0;
    end else begin
      ans_start_ff <= 1'b0;
      ans_valid_ff <= 1'b0;
      ans_last_ff <= 1'b0;
      outputs_upd_ff <= 1'b0;
      if (end_evt && !ans_busy_ff) begin
        ans_start_ff <= 1'b1;
        if (cur_kind == fbsd_pkg::FBSD_REQ_DIAG) begin
          ans_busy_ff <= 1'b1;
          ans_diag_ff <= 1'b1;
          dg_idx_ff <= 4'h0;
          snap_ff <= fault_ff;
          ans_kind_ff <= fbsd_pkg::FBSD_ANS_ACK;
        end else if (cur_kind == fbsd_pkg::FBSD_REQ_DATA && cfg_ok_ff && data_len_ok) begin
          ans_busy_ff <= 1'b1;
          ans_diag_ff <= 1'b0;
          ans_cnt_ff <= 8'h00;
          in_sh_ff <= inputs_img;
          outputs_img_ff <= {link.req_byte, out_sh_ff[8*IO_BYTES-1:8]};
          outputs_upd_ff <= 1'b1;
          ans_kind_ff <= diag_pend_ff ? fbsd_pkg::FBSD_ANS_DATA_HI
            : fbsd_pkg::FBSD_ANS_DATA_LO;
        end else if (cur_kind == fbsd_pkg::FBSD_REQ_PRM
          || cur_kind == fbsd_pkg::FBSD_REQ_CFG) begin
          ans_kind_ff <= fbsd_pkg::FBSD_ANS_ACK;
        end else begin
          ans_kind_ff <= fbsd_pkg::FBSD_ANS_NAK;
        end
      end else if (ans_busy_ff && ans_diag_ff) begin
        ans_valid_ff <= 1'b1;
        ans_byte_ff <= dg_byte;
        ans_last_ff <= diag_done;
        dg_idx_ff <= dg_idx_ff + 4'h1;
        if (diag_done) ans_busy_ff <= 1'b0;
      end else if (ans_busy_ff) begin
        ans_valid_ff <= 1'b1;
        ans_byte_ff <= in_sh_ff[7:0];
        in_sh_ff <= in_sh_ff >> 8;
        ans_last_ff <= ans_cnt_ff == 8'(IO_BYTES - 1);
        ans_cnt_ff <= ans_cnt_ff + 8'h01;
        if (ans_cnt_ff == 8'(IO_BYTES - 1)) ans_busy_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // internal bus query pacing
  logic [14:0] tick_ff;
  logic [15:0] ms_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_ff <= 15'h0000;
      ms_ff <= 16'h0000;
      poll_query_ff <= 1'b0;
    end else begin
      poll_query_ff <= 1'b0;
      if (tick_ff == 15'(TICKS_PER_MS - 1)) begin
        tick_ff <= 15'h0000;
        if (ms_ff + 16'h0001 >= poll_interval_ff) begin
          ms_ff <= 16'h0000;
          poll_query_ff <= 1'b1;
        end else begin
          ms_ff <= ms_ff + 16'h0001;
        end
      end else begin
        tick_ff <= tick_ff + 15'h0001;
      end
    end
  end

  assign link.ans_start = ans_start_ff;
  assign link.ans_kind = ans_kind_ff;
  assign link.ans_valid = ans_valid_ff;
  assign link.ans_last = ans_last_ff;
  assign link.ans_byte = ans_byte_ff;
endmodule // fbsd_slave

/* core/fbsd_defs.svh */
// constants for the fieldbus slave parameter/diagnostic block
// assumes inclusion by bare name from core/
`ifndef FBSD_DEFS_SVH
`define FBSD_DEFS_SVH
`define FBSD_PRM_STD_LEN 7
`define FBSD_PRM_IGNORED 3
`define FBSD_PRM_MAX_LEN 244
`define FBSD_UP_FMT_IDX 2
`define FBSD_UP_CYC_HI_IDX 3
`define FBSD_UP_CYC_LO_IDX 4
`define FBSD_UP_COUNT 8
`define FBSD_FMT_STANDARD 4'h0
`define FBSD_FMT_MIRROR 4'h1
`define FBSD_FMT_BCAST 4'h2
`define FBSD_FMT_SPECIAL 4'h3
`define FBSD_FMT_SPEC_BCAST 4'h4
`define FBSD_FMT_RESET 4'h0
`define FBSD_CYC_MIN 16'h000a
`define FBSD_CYC_MAX 16'hea60
`define FBSD_CYC_RESET 16'h0014
`define FBSD_CFG_B0 8'hc1
`define FBSD_CFG_B1 8'h15
`define FBSD_CFG_B2 8'h15
`define FBSD_CFG_B3 8'h00
`define FBSD_CFG_LEN 4
`define FBSD_IO_BYTES 22
`define FBSD_PZD_WORDS 7
`define FBSD_PKW_WORDS 4
`define FBSD_DIAG_STD_LEN 6
`define FBSD_DIAG_LEN 9
`define FBSD_DIAG_HDR 8'h03
`define FBSD_MS_NS 1000000
`define FBSD_CLK_NS 50
`define FBSD_TICKS_PER_MS (`FBSD_MS_NS / `FBSD_CLK_NS)
`define FBSD_APB_CMD 12'h000
`define FBSD_APB_STAT 12'h004
`define FBSD_APB_FMT 12'h008
`define FBSD_APB_CYC 12'h00c
`define FBSD_APB_FAULT 12'h010
`endif

/* core/fbsd_pkg.sv */
// types for the fieldbus slave parameter/diagnostic block
// assumes fbsd_defs.svh gives the numbers
package fbsd_pkg;
  typedef enum logic [2:0] {
    FBSD_REQ_NONE,
    FBSD_REQ_PRM,
    FBSD_REQ_CFG,
    FBSD_REQ_DATA,
    FBSD_REQ_DIAG
  } fbsd_req_type;
  typedef enum logic [1:0] {
    FBSD_ANS_ACK,
    FBSD_ANS_NAK,
    FBSD_ANS_DATA_LO,
    FBSD_ANS_DATA_HI
  } fbsd_ans_type;
endpackage

/* core/fbsd_link_if.sv */
// byte-serial link between fieldbus master and slave front end
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface fbsd_link_if;
  logic req_start;
  fbsd_pkg::fbsd_req_type req_kind;
  logic req_valid;
  logic req_last;
  logic [7:0] req_byte;
  logic ans_start;
  fbsd_pkg::fbsd_ans_type ans_kind;
  logic ans_valid;
  logic ans_last;
  logic [7:0] ans_byte;
  modport master (
    output req_start, req_kind, req_valid, req_last, req_byte,
    input ans_start, ans_kind, ans_valid, ans_last, ans_byte
  );
  modport slave (
    input req_start, req_kind, req_valid, req_last, req_byte,
    output ans_start, ans_kind, ans_valid, ans_last, ans_byte
  );
endinterface

/* core/fbsd_master.sv */
// master end: sends parameters, configuration, data and diagnostics requests
// assumes APB from software and the slave on the link interface
`timescale 1ns/1ps
`include "fbsd_defs.svh"
module fbsd_master #(
  parameter int IO_BYTES = `FBSD_IO_BYTES
) (
  input wire logic clock,
  input wire logic arst_n,
  fbsd_link_if.master link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [1:0] {FBSD_M_IDLE, FBSD_M_SEND, FBSD_M_WAIT} fbsd_mst_type;
  fbsd_mst_type st_ff;
  logic [3:0] fmt_ff;
  logic [15:0] cyc_ff;
  logic [10:0] fault_ff;
  logic hi_ff;
  logic ack_ff;
  logic [7:0] idx_ff;
  logic [7:0] len_ff;
  fbsd_pkg::fbsd_req_type kind_ff;
  logic busy;
  logic wr;
  logic bad_cyc;
  assign busy = st_ff != FBSD_M_IDLE;
  assign wr = psel && penable && pwrite;
  assign bad_cyc = pwdata[15:0] < `FBSD_CYC_MIN || pwdata[15:0] > `FBSD_CYC_MAX;

  // ==========================================================
  // apb slave, one-cycle access phase
  always_comb begin
    pready = 1'b1;
    pslverr = 1'b0;
    prdata = 32'h0000_0000;
    case (paddr)
      `FBSD_APB_CMD: prdata = 32'h0000_0000;
      `FBSD_APB_STAT: prdata = {28'h000_0000, hi_ff, ack_ff, 1'b0, busy};
      `FBSD_APB_FMT: prdata = {28'h000_0000, fmt_ff};
      `FBSD_APB_CYC: prdata = {16'h0000, cyc_ff};
      `FBSD_APB_FAULT: prdata = {21'h00_0000, fault_ff};
      default: pslverr = psel && penable;
    endcase
    if (wr && paddr == `FBSD_APB_CYC && bad_cyc) pslverr = 1'b1;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fmt_ff <= `FBSD_FMT_RESET;
      cyc_ff <= `FBSD_CYC_RESET;
    end else if (wr && paddr == `FBSD_APB_FMT) begin
      fmt_ff <= pwdata[3:0];
    end else if (wr && paddr == `FBSD_APB_CYC && !bad_cyc) begin
      cyc_ff <= pwdata[15:0];
    end
  end

  // ==========================================================
  // request sender
  logic [7:0] prm_byte;
  logic [7:0] cfg_byte;
  always_comb begin
    case (idx_ff)
      8'd12: prm_byte = {4'h0, fmt_ff};
      8'd13: prm_byte = cyc_ff[15:8];
      8'd14: prm_byte = cyc_ff[7:0];
      default: prm_byte = 8'h00;
    endcase
    case (idx_ff)
      8'h00: cfg_byte = `FBSD_CFG_B0;
      8'h01: cfg_byte = `FBSD_CFG_B1;
      8'h02: cfg_byte = `FBSD_CFG_B2;
      default: cfg_byte = `FBSD_CFG_B3;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= FBSD_M_IDLE;
      kind_ff <= fbsd_pkg::FBSD_REQ_NONE;
      idx_ff <= 8'h00;
      len_ff <= 8'h00;
      ack_ff <= 1'b0;
      hi_ff <= 1'b0;
      fault_ff <= 11'h000;
      link.req_start <= 1'b0;
      link.req_kind <= fbsd_pkg::FBSD_REQ_NONE;
      link.req_valid <= 1'b0;
      link.req_last <= 1'b0;
      link.req_byte <= 8'h00;
    end else begin
      link.req_start <= 1'b0;
      link.req_valid <= 1'b0;
      link.req_last <= 1'b0;
      case (st_ff)
        FBSD_M_IDLE: begin
          if (wr && paddr == `FBSD_APB_CMD && pwdata[2:0] != 3'h0) begin
            st_ff <= FBSD_M_SEND;
            idx_ff <= 8'h00;
            ack_ff <= 1'b0;
            case (pwdata[2:0])
              3'h1: begin
                kind_ff <= fbsd_pkg::FBSD_REQ_PRM;
                len_ff <= 8'(`FBSD_PRM_STD_LEN + `FBSD_PRM_IGNORED + `FBSD_UP_COUNT);
              end
              3'h2: begin
                kind_ff <= fbsd_pkg::FBSD_REQ_CFG;
                len_ff <= 8'(`FBSD_CFG_LEN);
              end
              3'h3: begin
                kind_ff <= fbsd_pkg::FBSD_REQ_DATA;
                len_ff <= 8'(IO_BYTES);
              end
              default: begin
                kind_ff <= fbsd_pkg::FBSD_REQ_DIAG;
                len_ff <= 8'h01;
              end
            endcase
          end
        end
        FBSD_M_SEND: begin
          link.req_start <= idx_ff == 8'h00;
          link.req_kind <= kind_ff;
          link.req_valid <= 1'b1;
          link.req_last <= idx_ff == len_ff - 8'h01;
          link.req_byte <= kind_ff == fbsd_pkg::FBSD_REQ_PRM ? prm_byte
            : kind_ff == fbsd_pkg::FBSD_REQ_CFG ? cfg_byte : 8'h00;
          idx_ff <= idx_ff + 8'h01;
          if (idx_ff == len_ff - 8'h01) st_ff <= FBSD_M_WAIT;
        end
        FBSD_M_WAIT: begin
          if (link.ans_start) begin
            ack_ff <= link.ans_kind != fbsd_pkg::FBSD_ANS_NAK;
            hi_ff <= link.ans_kind == fbsd_pkg::FBSD_ANS_DATA_HI;
            idx_ff <= 8'h00;
            if (kind_ff == fbsd_pkg::FBSD_REQ_PRM || kind_ff == fbsd_pkg::FBSD_REQ_CFG
              || link.ans_kind == fbsd_pkg::FBSD_ANS_NAK) st_ff <= FBSD_M_IDLE;
          end
          if (link.ans_valid) begin
            idx_ff <= idx_ff + 8'h01;
            if (kind_ff == fbsd_pkg::FBSD_REQ_DIAG && idx_ff == 8'h07) fault_ff[7:0] <= link.ans_byte;
            if (kind_ff == fbsd_pkg::FBSD_REQ_DIAG && idx_ff == 8'h08) begin
              fault_ff[10:8] <= link.ans_byte[2:0];
              hi_ff <= 1'b0;
            end
            if (link.ans_last) st_ff <= FBSD_M_IDLE;
          end
        end
        default: st_ff <= FBSD_M_IDLE;
      endcase
    end
  end
endmodule // fbsd_master

/* bench/fspd_link_asserts.sv */
// link-level checks between the two ends of the fieldbus slave block
// assumes the testbench top wires the link interface signals by name
`timescale 1ns/1ps
module fspd_link_asserts (
  input logic clock,
  input logic arst_n,
  input logic req_start,
  input fbsd_pkg::fbsd_req_type req_kind,
  input logic req_valid,
  input logic req_last,
  input logic [7:0] req_byte,
  input logic ans_start,
  input fbsd_pkg::fbsd_ans_type ans_kind,
  input logic ans_valid,
  input logic ans_last,
  input logic [7:0] ans_byte
);
  // ==========
  // request kind tracking
  fbsd_pkg::fbsd_req_type kind_ff;
  fbsd_pkg::fbsd_req_type cur_kind;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      kind_ff <= fbsd_pkg::FBSD_REQ_NONE;
    end else if (req_start && req_valid) begin
      kind_ff <= req_kind;
    end
  end
  assign cur_kind = req_start ? req_kind : kind_ff;
  // ==========
  // properties
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_ans_follows;
    req_valid && req_last |=> ans_start;
  endproperty
  a_ans_follows: assert property (p_ans_follows) else $error("no answer after request");
  property p_setup_ack;
    req_valid && req_last && (cur_kind inside {fbsd_pkg::FBSD_REQ_PRM, fbsd_pkg::FBSD_REQ_CFG})
      |=> ans_kind == fbsd_pkg::FBSD_ANS_ACK;
  endproperty
  a_setup_ack: assert property (p_setup_ack) else $error("setup request not acked");
  property p_diag_walk;
    req_valid && req_last && cur_kind == fbsd_pkg::FBSD_REQ_DIAG
      |=> ans_start && ans_kind == fbsd_pkg::FBSD_ANS_ACK ##1 ans_valid [*8]
      ##1 ans_valid && ans_last;
  endproperty
  a_diag_walk: assert property (p_diag_walk) else $error("diagnostic answer malformed");
  property p_diag_hdr;
    req_valid && req_last && cur_kind == fbsd_pkg::FBSD_REQ_DIAG
      |-> ##8 ans_valid && ans_byte == 8'h03;
  endproperty
  a_diag_hdr: assert property (p_diag_hdr) else $error("diagnostic header byte wrong");
  property p_data_len;
    ans_start && (ans_kind inside {fbsd_pkg::FBSD_ANS_DATA_LO, fbsd_pkg::FBSD_ANS_DATA_HI})
      |-> ##22 ans_valid && ans_last;
  endproperty
  a_data_len: assert property (p_data_len) else $error("data answer length wrong");
  property p_nak_empty;
    ans_start && ans_kind == fbsd_pkg::FBSD_ANS_NAK |=> !ans_valid ##1 !ans_valid;
  endproperty
  a_nak_empty: assert property (p_nak_empty) else $error("refusal carried bytes");
  property p_last_valid;
    ans_last |-> ans_valid && !ans_start;
  endproperty
  a_last_valid: assert property (p_last_valid) else $error("answer end without byte");
  property p_start_valid;
    req_start |-> req_valid;
  endproperty
  a_start_valid: assert property (p_start_valid) else $error("request start without byte");
endmodule // fspd_link_asserts

/* bench/fieldbus_slave_param_diag_tb_top.sv */
// testbench for master and slave ends joined by the link interface
// assumes core/ on the include path and APB driven from here
`timescale 1ns/1ps
`include "fbsd_defs.svh"
module fieldbus_slave_param_diag_tb_top;
  localparam int TPM = 5;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [10:0] bus_fault_evt = 11'h000;
  logic [175:0] inputs_img;
  logic [175:0] outputs_img;
  logic outputs_upd;
  logic [3:0] frame_format;
  logic [15:0] poll_interval;
  logic poll_query;
  logic prm_ok;
  logic cfg_ok;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int ans_cnt = 0;
  int upd_cnt = 0;
  logic [7:0] ans_buf [0:31];
  logic [31:0] rd;
  logic err;
  fbsd_link_if link ();
  fbsd_master fbsd_master_i (.clock(clock), .arst_n(arst_n), .link(link), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  fbsd_slave #(.TICKS_PER_MS(TPM)) fbsd_slave_i (.clock(clock), .arst_n(arst_n), .link(link),
    .bus_fault_evt(bus_fault_evt), .inputs_img(inputs_img), .outputs_img_ff(outputs_img),
    .outputs_upd_ff(outputs_upd), .frame_format_ff(frame_format),
    .poll_interval_ff(poll_interval), .poll_query_ff(poll_query), .prm_ok_ff(prm_ok),
    .cfg_ok_ff(cfg_ok));
  fspd_link_asserts fspd_link_asserts_i (.clock(clock), .arst_n(arst_n),
    .req_start(link.req_start), .req_kind(link.req_kind), .req_valid(link.req_valid),
    .req_last(link.req_last), .req_byte(link.req_byte), .ans_start(link.ans_start),
    .ans_kind(link.ans_kind), .ans_valid(link.ans_valid), .ans_last(link.ans_last),
    .ans_byte(link.ans_byte));
  always #25 clock = ~clock;
  // ==========
  // answer monitor and timeout
  always @(posedge clock) begin
    if (link.ans_start === 1'b1) begin
      ans_cnt <= 0;
    end else if (link.ans_valid === 1'b1) begin
      ans_buf[ans_cnt[4:0]] <= link.ans_byte;
      ans_cnt <= ans_cnt + 1;
    end
    if (outputs_upd === 1'b1) begin
      upd_cnt <= upd_cnt + 1;
    end
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      close_out();
    end
  end
  // ==========
  // shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // issue a command, leave last status word in rd
  task automatic cmd(input logic [31:0] c);
    apb(1'b1, `FBSD_APB_CMD, c);
    do begin
      apb(1'b0, `FBSD_APB_STAT, 32'h0000_0000);
    end while (rd[0] !== 1'b0);
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    check(32'(frame_format), 32'h0000_0000, "format after reset");
    check(32'(poll_interval), 32'h0000_0014, "interval after reset");
    check(32'(prm_ok), 32'h0000_0000, "parameters ok after reset");
    check(32'(cfg_ok), 32'h0000_0000, "configuration ok after reset");
    apb(1'b0, `FBSD_APB_CYC, 32'h0000_0000);
    check(rd, 32'h0000_0014, "cycle register after reset");
  endtask
  task automatic t_unconfigured();
    cmd(32'h0000_0003);
    check(32'(rd[2]), 32'h0000_0000, "data accepted before setup");
    check(32'(ans_cnt + upd_cnt), 32'h0000_0000, "data moved before setup");
    cmd(32'h0000_0004);
    check(32'(ans_cnt), 32'h0000_0009, "diagnostics before setup");
  endtask
  task automatic t_params();
    logic [15:0] c;
    apb(1'b1, `FBSD_APB_CYC, 32'h0000_0009);
    check(32'(err), 32'h0000_0001, "cycle 9 taken");
    apb(1'b1, `FBSD_APB_CYC, 32'h0000_ea61);
    check(32'(err), 32'h0000_0001, "cycle 60001 taken");
    for (int code = 0; code < 5; code++) begin
      c = (code == 4) ? 16'h000a : 16'hea60 - 16'(code);
      apb(1'b1, `FBSD_APB_FMT, 32'(code));
      apb(1'b1, `FBSD_APB_CYC, 32'(c));
      check(32'(err), 32'h0000_0000, "cycle in range refused");
      cmd(32'h0000_0001);
      check(32'(rd[2]), 32'h0000_0001, "parameters not acked");
      check(32'(prm_ok), 32'h0000_0001, "parameters not taken");
      check(32'(frame_format), 32'(code), "format decode");
      check(32'(poll_interval), 32'(c), "interval decode");
    end
    apb(1'b1, `FBSD_APB_FMT, 32'h0000_0005);
    cmd(32'h0000_0001);
    check(32'(frame_format), 32'h0000_0004, "undefined format taken");
    check(32'(poll_interval), 32'h0000_000a, "settings lost on reject");
  endtask
  task automatic t_poll();
    int n;
    n = 0;
    while (poll_query !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (poll_query !== 1'b1 && n < 200);
    check(32'(n), 32'(10 * TPM), "query spacing");
  endtask
  task automatic t_data();
    cmd(32'h0000_0002);
    check(32'(cfg_ok), 32'h0000_0001, "configuration not confirmed");
    cmd(32'h0000_0003);
    check(32'(rd[3]), 32'h0000_0000, "priority without fault");
    check(32'(ans_cnt), 32'h0000_0016, "input byte count");
    check(32'({ans_buf[21], ans_buf[0]}), 32'h0000_1601, "input image order");
    check(32'(upd_cnt), 32'h0000_0001, "output image update");
  endtask
  task automatic t_faults();
    for (int i = 0; i < 11; i++) begin
      @(posedge clock);
      bus_fault_evt <= 11'h001 << i;
      @(posedge clock);
      bus_fault_evt <= 11'h000;
      cmd(32'h0000_0003);
      check(32'(rd[3]), 32'h0000_0001, "fault not high priority");
      cmd(32'h0000_0004);
      check(32'({ans_buf[8], ans_buf[7]}), 32'h0000_0001 << i, "fault bytes");
      apb(1'b0, `FBSD_APB_FAULT, 32'h0000_0000);
      check(rd & 32'h0000_07ff, 32'h0000_0001 << i, "fault register");
    end
    cmd(32'h0000_0004);
    check(32'({ans_buf[8], ans_buf[7]}), 32'h0000_0000, "faults not cleared");
    cmd(32'h0000_0003);
    check(32'(rd[3]), 32'h0000_0000, "priority stuck high");
  endtask
  // ==========
  // main sequence
  initial begin
    for (int k = 0; k < 22; k++) begin
      inputs_img[8*k +: 8] = 8'(k + 1);
    end
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_unconfigured();
    t_params();
    t_poll();
    t_data();
    t_faults();
    close_out();
  end
endmodule // fieldbus_slave_param_diag_tb_top
